// [design/vpc_map.vh]
// Constants for the pulse-count acquisition block
// Summary of operation
// - One pulse counter per converter channel counts pulses in each 1 ms interval.
// - Controller sums interval counts over a configurable period, then emits sample code.
// - Fastest per-channel sampling is 1 kHz: one 1 ms interval, lowest accuracy.
// - Below maximum rate, accumulated counts are averaged before each sample code.
// - Specified operating acquisition rates run from 5 Hz to 100 Hz.
// - One to eight submodules, one or two channels each, sixteen counters.
// - Fitted submodules and their types are readable by host logic.
// - Converter pulses are locked to a 250 kHz reference; rate proportional to input.
// - Resolution grows with period length; 15-bit result needs 160 ms.
// - Each submodule has a serial memory with calibration, serial number, type.
// - Resistance submodule has one channel; second channel position is unused.
`ifndef VPC_MAP_VH
`define VPC_MAP_VH
`define VPC_CLK_PERIOD_NS 50
`define VPC_INTERVAL_NS 1000000
`define VPC_INTERVAL_CYCLES (`VPC_INTERVAL_NS / `VPC_CLK_PERIOD_NS)
`define VPC_REF_HZ 250000
`define VPC_INTERVAL_MAX_PULSES (`VPC_REF_HZ / 1000)
`define VPC_RATE_MIN_HZ 5
`define VPC_RATE_MAX_HZ 100
`define VPC_PERIOD_MAX_MS (1000 / `VPC_RATE_MIN_HZ)
`define VPC_PERIOD_15BIT_MS 160
`define VPC_SLOTS 8
`define VPC_CHANNELS 16
`define VPC_CNT_W 10
`define VPC_SUM_W 16
`define VPC_FRAC_W 8
`define VPC_CODE_W 16
`define VPC_SK_HALF_NS 1000
`define VPC_SK_HALF_CYCLES (`VPC_SK_HALF_NS / `VPC_CLK_PERIOD_NS)
`define VPC_EE_ADDR_W 6
`define VPC_EE_DATA_W 16
`define VPC_EE_READ_OP 3'h6
`define VPC_EE_TX_BITS 9
`define VPC_EE_FRAME_BITS 25
`endif

// [design/vpc_pulse_counter.v]
// One converter channel: input synchroniser, edge detector and 1 ms counter
`timescale 1ns/1ns
`default_nettype none
`include "vpc_map.vh"
module vpc_pulse_counter #(
  parameter CNT_W = `VPC_CNT_W
) (
  input wire clk,
  input wire reset_n,
  input wire pulse_in,
  input wire tick,
  output reg [CNT_W-1:0] count_out
);
  reg sync_a;
  reg sync_b;
  reg sync_c;
  reg [CNT_W-1:0] cnt;
  wire rise;
  wire [CNT_W-1:0] cnt_inc;

  assign rise = sync_b & ~sync_c;
  // Saturate rather than wrap on an overdriven input
  assign cnt_inc = (rise && (cnt != {CNT_W{1'b1}})) ? cnt + {{(CNT_W-1){1'b0}}, 1'b1} : cnt;

  always @(posedge clk) begin
    if (!reset_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= pulse_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      cnt <= {CNT_W{1'b0}};
      count_out <= {CNT_W{1'b0}};
    end else if (tick) begin
      // Edge seen on the boundary cycle goes into the closing interval
      count_out <= cnt_inc;
      cnt <= {CNT_W{1'b0}};
    end else begin
      cnt <= cnt_inc;
    end
  end
endmodule // vpc_pulse_counter
`default_nettype wire

// [design/vpc_cal_reader.v]
// Serial calibration memory reader shared by all submodule slots
`timescale 1ns/1ns
`default_nettype none
`include "vpc_map.vh"
module vpc_cal_reader #(
  parameter SK_HALF = `VPC_SK_HALF_CYCLES
) (
  input wire clk,
  input wire reset_n,
  input wire req,
  input wire [2:0] slot,
  input wire [`VPC_EE_ADDR_W-1:0] addr,
  input wire miso,
  output reg [`VPC_SLOTS-1:0] cs,
  output reg sk,
  output reg mosi,
  output reg busy,
  output reg done,
  output reg [`VPC_EE_DATA_W-1:0] rdata
);
  reg miso_a;
  reg miso_b;
  reg [7:0] phase;
  reg [4:0] bit_idx;
  reg [`VPC_EE_TX_BITS-1:0] tx;
  reg [`VPC_EE_DATA_W-1:0] rx;

  always @(posedge clk) begin
    if (!reset_n) begin
      miso_a <= 1'b0;
      miso_b <= 1'b0;
    end else begin
      miso_a <= miso;
      miso_b <= miso_a;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      cs <= {`VPC_SLOTS{1'b0}};
      sk <= 1'b0;
      mosi <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= {`VPC_EE_DATA_W{1'b0}};
      phase <= 8'h00;
      bit_idx <= 5'h00;
      tx <= {`VPC_EE_TX_BITS{1'b0}};
      rx <= {`VPC_EE_DATA_W{1'b0}};
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (req) begin
          // Start bit and read opcode, then word address
          busy <= 1'b1;
          cs <= {{(`VPC_SLOTS-1){1'b0}}, 1'b1} << slot;
          tx <= {`VPC_EE_READ_OP, addr};
          mosi <= 1'b1;
          phase <= 8'h00;
          bit_idx <= 5'h00;
        end
      end else if (phase == SK_HALF[7:0] - 8'h01) begin
        phase <= 8'h00;
        if (!sk) begin
          sk <= 1'b1;
        end else begin
          sk <= 1'b0;
          // Data is sampled at the end of the high phase after sync delay
          if (bit_idx >= `VPC_EE_TX_BITS) begin
            rx <= {rx[`VPC_EE_DATA_W-2:0], miso_b};
          end
          if (bit_idx == `VPC_EE_FRAME_BITS - 1) begin
            busy <= 1'b0;
            done <= 1'b1;
            cs <= {`VPC_SLOTS{1'b0}};
            mosi <= 1'b0;
            rdata <= {rx[`VPC_EE_DATA_W-2:0], miso_b};
          end else begin
            bit_idx <= bit_idx + 5'h01;
            tx <= {tx[`VPC_EE_TX_BITS-2:0], 1'b0};
            mosi <= tx[`VPC_EE_TX_BITS-2];
          end
        end
      end else begin
        phase <= phase + 8'h01;
      end
    end
  end
endmodule // vpc_cal_reader
`default_nettype wire

// [design/vpc_acq_top.v]
// Pulse-count acquisition: counters, period accumulation, averaging, slot map
`timescale 1ns/1ns
`default_nettype none
`include "vpc_map.vh"
module vpc_acq_top #(
  parameter INTERVAL_CYCLES = `VPC_INTERVAL_CYCLES,
  parameter SK_HALF = `VPC_SK_HALF_CYCLES
) (
  input wire clk,
  input wire reset_n,
  input wire [`VPC_CHANNELS-1:0] conv_pulse,
  input wire [`VPC_SLOTS-1:0] slot_fitted,
  input wire [`VPC_SLOTS-1:0] slot_single,
  input wire [7:0] period_ms,
  input wire cal_req,
  input wire [2:0] cal_slot,
  input wire [`VPC_EE_ADDR_W-1:0] cal_addr,
  input wire cal_miso,
  output reg sample_valid,
  output reg [3:0] sample_chan,
  output reg [`VPC_CODE_W-1:0] sample_code,
  output reg [`VPC_SLOTS-1:0] fitted_config,
  output reg [`VPC_SLOTS-1:0] single_config,
  output reg [`VPC_CHANNELS-1:0] chan_active,
  output reg interval_tick,
  output wire [`VPC_SLOTS-1:0] cal_cs,
  output wire cal_sk,
  output wire cal_mosi,
  output wire cal_busy,
  output wire cal_done,
  output wire [`VPC_EE_DATA_W-1:0] cal_rdata
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DIV = 3'b010;
  localparam ST_EMIT = 3'b100;
  localparam DIV_W = `VPC_SUM_W + `VPC_FRAC_W;
  localparam DIV_LAST = DIV_W - 1;
  localparam PERIOD_MAX_I = `VPC_PERIOD_MAX_MS;
  localparam [7:0] PERIOD_MAX = PERIOD_MAX_I[7:0];

  reg [`VPC_SLOTS-1:0] fit_a;
  reg [`VPC_SLOTS-1:0] fit_b;
  reg [`VPC_SLOTS-1:0] sgl_a;
  reg [`VPC_SLOTS-1:0] sgl_b;
  reg [15:0] tick_cnt;
  reg tick;
  reg tick_d;
  reg [7:0] ms_cnt;
  reg [7:0] period_cur;
  reg [7:0] period_hold;
  reg [`VPC_SUM_W-1:0] sum [0:`VPC_CHANNELS-1];
  reg [`VPC_SUM_W-1:0] hold [0:`VPC_CHANNELS-1];
  reg [2:0] state;
  reg [3:0] chan;
  reg [4:0] step;
  reg [DIV_W-1:0] dvd;
  reg [8:0] rem;
  reg [8:0] next_rem;
  reg [8:0] trial;
  reg next_q;
  // Active map frozen at period end so one burst follows one slot map
  reg [`VPC_CHANNELS-1:0] burst_map;
  wire [`VPC_CNT_W-1:0] cap [0:`VPC_CHANNELS-1];
  wire period_end;
  wire [7:0] period_clamped;
  integer i;
  genvar g;

  // Channel position is live only when its slot is fitted and, for the
  // upper position, the slot is not a single-channel resistance type
  function chan_used;
    input [3:0] ch;
    input [`VPC_SLOTS-1:0] fit;
    input [`VPC_SLOTS-1:0] sgl;
    begin
      chan_used = fit[ch[3:1]] & ~(ch[0] & sgl[ch[3:1]]);
    end
  endfunction

  // Interval count added to a running sum; holds at full scale instead of wrapping
  function [`VPC_SUM_W-1:0] acc_add;
    input [`VPC_SUM_W-1:0] acc;
    input [`VPC_CNT_W-1:0] cnt;
    reg [`VPC_SUM_W:0] wide;
    begin
      wide = {1'b0, acc} + {{(`VPC_SUM_W+1-`VPC_CNT_W){1'b0}}, cnt};
      if (wide[`VPC_SUM_W]) begin
        acc_add = {`VPC_SUM_W{1'b1}};
      end else begin
        acc_add = wide[`VPC_SUM_W-1:0];
      end
    end
  endfunction

  // Period limited to 1 ms .. slowest specified rate
  assign period_clamped = (period_ms == 8'h00) ? 8'h01 :
    ((period_ms > PERIOD_MAX) ? PERIOD_MAX : period_ms);
  assign period_end = tick_d && (ms_cnt == period_cur - 8'h01);

  generate
    for (g = 0; g < `VPC_CHANNELS; g = g + 1) begin : gen_cnt
      // Width covers 250 pulses per interval with headroom
      vpc_pulse_counter #(
        .CNT_W(`VPC_CNT_W)
      ) u_cnt (
        .clk(clk),
        .reset_n(reset_n),
        .pulse_in(conv_pulse[g]),
        .tick(tick),
        .count_out(cap[g])
      );
    end
  endgenerate

  vpc_cal_reader #(
    .SK_HALF(SK_HALF)
  ) u_cal (
    .clk(clk),
    .reset_n(reset_n),
    .req(cal_req),
    .slot(cal_slot),
    .addr(cal_addr),
    .miso(cal_miso),
    .cs(cal_cs),
    .sk(cal_sk),
    .mosi(cal_mosi),
    .busy(cal_busy),
    .done(cal_done),
    .rdata(cal_rdata)
  );

  // Slot straps come from the board: two-stage synchroniser
  always @(posedge clk) begin
    if (!reset_n) begin
      fit_a <= {`VPC_SLOTS{1'b0}};
      fit_b <= {`VPC_SLOTS{1'b0}};
      sgl_a <= {`VPC_SLOTS{1'b0}};
      sgl_b <= {`VPC_SLOTS{1'b0}};
      fitted_config <= {`VPC_SLOTS{1'b0}};
      single_config <= {`VPC_SLOTS{1'b0}};
      chan_active <= {`VPC_CHANNELS{1'b0}};
    end else begin
      fit_a <= slot_fitted;
      fit_b <= fit_a;
      sgl_a <= slot_single;
      sgl_b <= sgl_a;
      fitted_config <= fit_b;
      single_config <= sgl_b & fit_b;
      for (i = 0; i < `VPC_CHANNELS; i = i + 1) begin
        chan_active[i] <= chan_used(i[3:0], fit_b, sgl_b);
      end
    end
  end

  // 1 ms interval timebase
  always @(posedge clk) begin
    if (!reset_n) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
      tick_d <= 1'b0;
      interval_tick <= 1'b0;
    end else begin
      tick_d <= tick;
      interval_tick <= tick;
      if (tick_cnt == INTERVAL_CYCLES[15:0] - 16'h0001) begin
        tick_cnt <= 16'h0000;
        tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
        tick <= 1'b0;
      end
    end
  end

  // Accumulate captured interval counts over the measurement period
  always @(posedge clk) begin
    if (!reset_n) begin
      ms_cnt <= 8'h00;
      period_cur <= 8'h01;
      period_hold <= 8'h01;
      for (i = 0; i < `VPC_CHANNELS; i = i + 1) begin
        sum[i] <= {`VPC_SUM_W{1'b0}};
        hold[i] <= {`VPC_SUM_W{1'b0}};
      end
    end else if (tick_d) begin
      if (period_end) begin
        ms_cnt <= 8'h00;
        period_hold <= period_cur;
        period_cur <= period_clamped;
        for (i = 0; i < `VPC_CHANNELS; i = i + 1) begin
          hold[i] <= acc_add(sum[i], cap[i]);
          sum[i] <= {`VPC_SUM_W{1'b0}};
        end
      end else begin
        ms_cnt <= ms_cnt + 8'h01;
        for (i = 0; i < `VPC_CHANNELS; i = i + 1) begin
          sum[i] <= acc_add(sum[i], cap[i]);
        end
      end
    end
  end

  always @* begin
    trial = {rem[7:0], dvd[DIV_W-1]};
    next_q = (trial >= {1'b0, period_hold});
    if (next_q) begin
      next_rem = trial - {1'b0, period_hold};
    end else begin
      next_rem = trial;
    end
  end

  // Averaging: code = sum * 2^FRAC / period, one channel after another
  always @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      chan <= 4'h0;
      step <= 5'h00;
      dvd <= {DIV_W{1'b0}};
      rem <= 9'h000;
      sample_valid <= 1'b0;
      sample_chan <= 4'h0;
      sample_code <= {`VPC_CODE_W{1'b0}};
      burst_map <= {`VPC_CHANNELS{1'b0}};
    end else begin
      sample_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (tick_d && period_end) begin
            chan <= 4'h0;
            burst_map <= chan_active;
            state <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          // Unused positions produce no sample
          if (burst_map[chan]) begin
            dvd <= {hold[chan], {`VPC_FRAC_W{1'b0}}};
            rem <= 9'h000;
            step <= 5'h00;
            state <= ST_DIV;
          end else if (chan == 4'hf) begin
            state <= ST_IDLE;
          end else begin
            chan <= chan + 4'h1;
          end
        end
        ST_DIV: begin
          rem <= next_rem;
          dvd <= {dvd[DIV_W-2:0], next_q};
          if (step == DIV_LAST[4:0]) begin
            sample_valid <= 1'b1;
            sample_chan <= chan;
            if (dvd[DIV_W-2:`VPC_CODE_W-1] != {(DIV_W-`VPC_CODE_W){1'b0}}) begin
              sample_code <= {`VPC_CODE_W{1'b1}};
            end else begin
              sample_code <= {dvd[`VPC_CODE_W-2:0], next_q};
            end
            if (chan == 4'hf) begin
              state <= ST_IDLE;
            end else begin
              chan <= chan + 4'h1;
              state <= ST_EMIT;
            end
          end else begin
            step <= step + 5'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // vpc_acq_top
`default_nettype wire

// [dv/vpc_acq_asserts.sv]
// Concurrent checks on the acquisition top ports
`timescale 1ns/1ns
`default_nettype none
module vpc_acq_asserts #(
  parameter INTERVAL_CYCLES = 500
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] slot_fitted,
  input wire logic cal_req,
  input wire logic [2:0] cal_slot,
  input wire logic sample_valid,
  input wire logic [3:0] sample_chan,
  input wire logic [7:0] fitted_config,
  input wire logic [15:0] chan_active,
  input wire logic interval_tick,
  input wire logic [7:0] cal_cs,
  input wire logic cal_mosi,
  input wire logic cal_busy,
  input wire logic cal_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  int tc;
  logic seen;
  logic [5:0] sg;
  logic [3:0] pc;
  // Cycles since the last tick, and gap and channel of the last sample
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tc <= 0;
      seen <= 1'b0;
      sg <= 6'h3f;
      pc <= 4'h0;
    end else begin
      tc <= interval_tick ? 0 : tc + 1;
      seen <= seen | interval_tick;
      if (sample_valid) begin
        sg <= 6'h00;
        pc <= sample_chan;
      end else if (sg != 6'h3f) begin
        sg <= sg + 6'h01;
      end
    end
  end
  sequence s_cal_take;
    cal_req && !cal_busy;
  endsequence
  sequence s_cal_run;
    cal_busy [*8] ##[1:400] cal_done;
  endsequence
  AST_TICK_PERIOD: assert property (interval_tick && seen |-> tc == INTERVAL_CYCLES - 1)
    else $error("interval tick spacing");
  AST_VALID_ONE: assert property (sample_valid |=> !sample_valid [*8])
    else $error("samples too close");
  AST_CHAN_USED: assert property (sample_valid |-> chan_active[sample_chan])
    else $error("sample on unused channel");
  AST_CFG_FOLLOW: assert property ($stable(slot_fitted) [*5] |-> fitted_config == slot_fitted)
    else $error("fitted map stale");
  AST_ORDER: assert property (sample_valid && sg < 6'h3c |-> sample_chan > pc)
    else $error("channel order");
  AST_CAL_START: assert property (s_cal_take |=> cal_busy && cal_mosi && cal_cs == 8'h01 << $past(cal_slot))
    else $error("memory read start");
  AST_CAL_LEN: assert property (s_cal_take |=> s_cal_run)
    else $error("memory read length");
  AST_CAL_END: assert property (cal_done |-> !cal_busy && cal_cs == 8'h00)
    else $error("memory read end");
  AST_CS_ONE: assert property ($onehot0(cal_cs))
    else $error("memory select not one-hot");
endmodule // vpc_acq_asserts
bind vpc_acq_top vpc_acq_asserts #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) u_chk (
  .clk(clk), .reset_n(reset_n), .slot_fitted(slot_fitted), .cal_req(cal_req),
  .cal_slot(cal_slot), .sample_valid(sample_valid), .sample_chan(sample_chan),
  .fitted_config(fitted_config), .chan_active(chan_active), .interval_tick(interval_tick),
  .cal_cs(cal_cs), .cal_mosi(cal_mosi), .cal_busy(cal_busy), .cal_done(cal_done)
);
`default_nettype wire

// [dv/vpc_vfc_model.sv]
// Converter pulse trains and calibration memories of the submodules
`timescale 1ns/1ns
`default_nettype none
module vpc_vfc_model (
  input wire logic clk,
  input wire logic interval_tick,
  input wire logic [63:0] rate,
  input wire logic [7:0] cal_cs,
  input wire logic cal_sk,
  input wire logic cal_mosi,
  output logic [15:0] conv_pulse = 16'h0000,
  output logic cal_miso
);
  logic [5:0] ph = 6'h3f;
  logic [4:0] n = 5'h00;
  logic [8:0] cmd = 9'h000;
  logic m = 1'b0;
  logic tgl = 1'b0;
  wire logic cs_any = |cal_cs;
  wire logic [15:0] word = {cal_cs, cmd[7:0]};
  // Each converter gives rate pulses per interval, two cycles high, two low
  always @(posedge clk) begin
    ph <= interval_tick ? 6'h00 : (ph == 6'h3f ? ph : ph + 6'h01);
    tgl <= ~tgl;
    for (int c = 0; c < 16; c++)
      conv_pulse[c] <= ph < {rate[4*c +: 4], 2'b00} && ph[1];
  end
  // Nine command bits in, then the word out MSB first; data line toggles otherwise
  always @(posedge cal_sk or posedge cs_any) begin
    if (!cal_sk) begin
      n <= 5'h00;
    end else if (n < 5'h09) begin
      cmd <= {cmd[7:0], cal_mosi};
      m <= ~m;
      n <= n + 5'h01;
    end else begin
      m <= word[5'h18 - n];
      n <= n + 5'h01;
    end
  end
  assign cal_miso = cs_any ? m : tgl;
endmodule // vpc_vfc_model
`default_nettype wire

// [dv/test_vfc_pulse_count_acquisition.sv]
// Self-checking bench for the pulse-count acquisition top
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module test_vfc_pulse_count_acquisition;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] fit = 8'h01;
  logic [7:0] sgl = 8'h00;
  logic [7:0] period_ms = 8'h01;
  logic cal_req = 1'b0;
  logic [2:0] cal_slot = 3'h0;
  logic [5:0] cal_addr = 6'h00;
  logic [63:0] rate = 64'h0;
  logic chk_on = 1'b0;
  logic [15:0] act;
  logic [19:0] e;
  logic [15:0] ce;
  logic [19:0] sq[$];
  logic [15:0] cq[$];
  int failures = 0;
  int compares = 0;
  wire logic sample_valid, interval_tick, cal_sk, cal_mosi, cal_busy, cal_done, cal_miso;
  wire logic [3:0] sample_chan;
  wire logic [15:0] sample_code, chan_active, cal_rdata, conv_pulse;
  wire logic [7:0] fitted_config, single_config, cal_cs;
  vpc_acq_top #(.INTERVAL_CYCLES(500), .SK_HALF(4)) uut (
    .clk(clk), .reset_n(reset_n), .conv_pulse(conv_pulse), .slot_fitted(fit),
    .slot_single(sgl), .period_ms(period_ms), .cal_req(cal_req), .cal_slot(cal_slot),
    .cal_addr(cal_addr), .cal_miso(cal_miso), .sample_valid(sample_valid),
    .sample_chan(sample_chan), .sample_code(sample_code), .fitted_config(fitted_config),
    .single_config(single_config), .chan_active(chan_active), .interval_tick(interval_tick),
    .cal_cs(cal_cs), .cal_sk(cal_sk), .cal_mosi(cal_mosi), .cal_busy(cal_busy),
    .cal_done(cal_done), .cal_rdata(cal_rdata)
  );
  vpc_vfc_model u_vfc (
    .clk(clk), .interval_tick(interval_tick), .rate(rate), .cal_cs(cal_cs),
    .cal_sk(cal_sk), .cal_mosi(cal_mosi), .conv_pulse(conv_pulse), .cal_miso(cal_miso)
  );
  always #25 clk = ~clk;
  always @(negedge clk) begin
    if (sample_valid === 1'b1 && chk_on) begin
      e = sq.pop_front();
      `CHK("sample", e, {sample_chan, sample_code})
    end
    if (cal_done === 1'b1) begin
      ce = cq.pop_front();
      `CHK("cal word", ce, cal_rdata)
    end
  end
  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_last(input int last);
    int t;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (!(sample_valid === 1'b1 && sample_chan == last) && t < 8000);
    `CHK("burst wait", 1'b1, t < 8000)
  endtask
  task automatic cal_rd(input logic [2:0] s, input logic [5:0] a);
    int t;
    @(posedge clk);
    cal_req <= 1'b1;
    cal_slot <= s;
    cal_addr <= a;
    cq.push_back({8'h01 << s, 2'b10, a});
    @(posedge clk);
    cal_req <= 1'b0;
    repeat (20) @(posedge clk);
    cal_req <= 1'b1;
    cal_slot <= ~s;
    cal_addr <= ~a;
    @(posedge clk);
    cal_req <= 1'b0;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (cal_done !== 1'b1 && t < 1000);
    `CHK("cal wait", 1'b1, t < 1000)
    @(posedge clk);
  endtask
  task automatic phase(input logic [7:0] p);
    int last;
    @(posedge clk);
    fit <= 8'($urandom) | 8'h01;
    sgl <= 8'($urandom);
    rate <= {$urandom, $urandom};
    period_ms <= p;
    repeat (6) @(posedge clk);
    @(negedge clk);
    for (int s = 0; s < 8; s++) act[2*s +: 2] = {fit[s] & ~sgl[s], fit[s]};
    `CHK("fitted", fit, fitted_config)
    `CHK("single", fit & sgl, single_config)
    `CHK("active", act, chan_active)
    last = 0;
    for (int c = 0; c < 16; c++) if (act[c]) last = c;
    repeat (3) wait_last(last);
    @(posedge clk);
    repeat (2) for (int c = 0; c < 16; c++)
      if (act[c]) sq.push_back({c[3:0], 4'h0, rate[4*c +: 4], 8'h00});
    chk_on = 1'b1;
    repeat (2) wait_last(last);
    @(posedge clk);
    `CHK("samples left", 0, sq.size())
    chk_on = 1'b0;
  endtask
  initial begin
    #4500000;
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(43292));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) cal_rd(i[2:0], 6'($urandom));
    wait_last(1);
    phase(8'h00);
    phase(8'h01);
    phase(8'h02);
    phase(8'h04);
    final_report();
  end
endmodule // test_vfc_pulse_count_acquisition
`default_nettype wire
